// ==== logic/fclg_guard.sv ====
`timescale 1ns/10ps
// command decoder and error protection for the flash sequencer
module fclg_guard
	import fclg_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_cmd_wr,
	input wire logic i_cmd_rd,
	input wire logic [fclg_pkg::DATA_W-1:0] i_cmd_data,
	input wire logic [1:0] i_cmd_size,
	input wire logic [fclg_pkg::MODE_W-1:0] i_mode_entry_reg,
	input wire logic [fclg_pkg::ADDR_W-1:0] i_start_address,
	input wire logic [fclg_pkg::ADDR_W-1:0] i_end_address,
	input wire logic i_blank_check_direction,
	input wire logic i_lock_irq_enable,
	input wire logic i_high_voltage_enable_ctrl,
	input wire logic i_valid_area_hit,
	input wire logic i_protect_violation,
	input wire logic i_dma_area_cross,
	input wire logic i_op_done,
	input wire logic i_op_fail,
	input wire logic [fclg_pkg::NECC-1:0] i_ecc_detect,
	output logic o_sequencer_ready_flag,
	output logic o_op_start,
	output logic [1:0] o_op_kind,
	output logic o_op_suspend,
	output logic o_op_resume,
	output logic o_op_abort,
	output logic o_flash_access_error_irq,
	output logic o_lock_status_bit,
	output logic o_illegal_error_bit,
	output logic o_illegal_command_bit,
	output logic o_mode_setting_error_bit,
	output logic o_erase_error_bit,
	output logic o_program_error_bit,
	output logic o_code_area_access_error,
	output logic o_data_area_access_error,
	output logic o_security_error_bit,
	output logic o_operation_timing_error,
	output logic o_high_voltage_enable_error,
	output logic o_security_area_ecc_detect,
	output logic o_protect_area_ecc_detect,
	output logic o_config_area_ecc_detect,
	output logic o_param_table_ecc_detect,
	output logic o_switch_area_ecc_detect,
	output logic o_erase_count_ecc_detect
);
	import fclg_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed
	{
		fclg_state_t state;
		fclg_op_t op;
		logic [CNT_W-1:0] cnt;
		logic [MODE_W-1:0] susp_mode;
		logic hv_prev;
		logic ready;
		logic start;
		logic suspend;
		logic resume;
		logic abort;
		logic irq;
	} fclg_core_t;

	fclg_core_t st;
	fclg_core_t next_st;
	logic [NERR-1:0] err_set;
	logic err_clr;
	logic [NERR-1:0] errs;
	logic locked;
	logic mode_ok;
	logic addr_bad;

	assign locked = errs[B_LOCK];
	// only three mode entry values are legal
	assign mode_ok = (i_mode_entry_reg == MODE_READ) || (i_mode_entry_reg == MODE_CODE_PE)
		|| (i_mode_entry_reg == MODE_DATA_PE);

	// address order check for the ranged commands
	always_comb
	begin
		addr_bad = 1'b0;
		if (st.op == OP_AERASE)
		begin
			addr_bad = i_start_address > i_end_address;
		end
		else if (st.op == OP_BLANK)
		begin
			addr_bad = i_blank_check_direction ? (i_start_address < i_end_address)
				: (i_start_address > i_end_address);
		end
	end

	// ----------------------------------------------------------------
	// command decoder and error classification
	// ----------------------------------------------------------------
	// one process decides both the next state and which sticky bits to set;
	// any set of the illegal bit also sets the lock bit at the end
	always_comb
	begin
		next_st = st;
		next_st.start = 1'b0;
		next_st.suspend = 1'b0;
		next_st.resume = 1'b0;
		next_st.abort = 1'b0;
		next_st.hv_prev = i_high_voltage_enable_ctrl;
		err_set = '0;
		err_clr = 1'b0;

		// operation finishing in the background
		if (st.state == ST_BUSY && i_op_done)
		begin
			next_st.state = ST_IDLE;
			if (i_op_fail && st.op == OP_PROG)
			begin
				err_set[B_PRG] = 1'b1;
			end
			else if (i_op_fail && st.op != OP_BLANK)
			begin
				err_set[B_ERS] = 1'b1;
			end
		end

		// hv enable dropping while the sequencer works
		if (st.hv_prev && !i_high_voltage_enable_ctrl && st.state != ST_IDLE)
		begin
			err_set[B_HVE] = 1'b1;
		end

		if (i_cmd_rd)
		begin
			err_set[B_OT] = 1'b1;
			err_set[B_ILGL] = 1'b1;
		end

		if (i_dma_area_cross)
		begin
			err_set[B_DFA] = 1'b1;
			err_set[B_ILGL] = 1'b1;
		end

		if (i_cmd_wr)
		begin
			if (i_cmd_data == CMD_FSTOP && st.state != ST_DATA)
			begin
				// stop works in every state except ST_DATA and ignores the ready flag
				err_clr = 1'b1;
				next_st.abort = (st.state == ST_BUSY) || (st.state == ST_SUSP);
				next_st.state = ST_IDLE;
			end
			else if (locked && i_cmd_data == CMD_CLEAR && st.state != ST_BUSY)
			begin
				// besides stop, clear is the one command a ready, locked sequencer still takes
				err_clr = 1'b1;
			end
			else if (locked)
			begin
				// nothing is decoded; a suspend here does not reach the array
				err_set[B_ILGL] = 1'b1;
				err_set[B_ILGL] = 1'b1;
			end
			else
			begin
				unique case (st.state)
					ST_IDLE, ST_SUSP:
					begin
						if (!mode_ok)
						begin
							err_set[B_MODE] = 1'b1;
							err_set[B_ILGL] = 1'b1;
						end
						else if (i_mode_entry_reg == MODE_READ && i_cmd_data != CMD_CLEAR)
						begin
							err_set[B_OT] = 1'b1;
							err_set[B_ILGL] = 1'b1;
						end
						else if (i_cmd_size != SIZE_BYTE)
						begin
							err_set[B_ILGCOM] = 1'b1;
							err_set[B_ILGL] = 1'b1;
						end
						else if (i_cmd_data == CMD_CLEAR)
						begin
							err_clr = 1'b1;
						end
						else if (i_cmd_data == CMD_FINAL && st.state == ST_SUSP)
						begin
							if (i_mode_entry_reg != st.susp_mode)
							begin
								err_set[B_ILGL] = 1'b1;
							end
							else if (i_valid_area_hit)
							begin
								err_set[B_CFA] = 1'b1;
								err_set[B_ILGL] = 1'b1;
							end
							else
							begin
								next_st.resume = 1'b1;
								next_st.state = ST_BUSY;
							end
						end
						else if (i_cmd_data == CMD_PROG && st.state == ST_IDLE)
						begin
							next_st.op = OP_PROG;
							next_st.state = ST_COUNT;
						end
						else if (i_cmd_data == CMD_BLK_ERASE && st.state == ST_IDLE)
						begin
							next_st.op = OP_BERASE;
							next_st.state = ST_FINAL;
						end
						else if (i_cmd_data == CMD_AREA_ERASE && st.state == ST_IDLE)
						begin
							next_st.op = OP_AERASE;
							next_st.state = ST_FINAL;
						end
						else if (i_cmd_data == CMD_BLANK && st.state == ST_IDLE)
						begin
							next_st.op = OP_BLANK;
							next_st.state = ST_FINAL;
						end
						else
						begin
							err_set[B_ILGCOM] = 1'b1;
							err_set[B_ILGL] = 1'b1;
						end
					end
					ST_COUNT:
					begin
						if (i_cmd_size != SIZE_BYTE || i_cmd_data != PROG_WORDS)
						begin
							err_set[B_ILGCOM] = 1'b1;
							err_set[B_ILGL] = 1'b1;
						end
						else
						begin
							next_st.cnt = PROG_CNT;
							next_st.state = ST_DATA;
						end
					end
					ST_DATA:
					begin
						if (i_cmd_size != SIZE_WORD)
						begin
							err_set[B_ILGCOM] = 1'b1;
							err_set[B_ILGL] = 1'b1;
						end
						else
						begin
							next_st.cnt = st.cnt - CNT_ONE;
							if (st.cnt == CNT_ONE)
							begin
								next_st.state = ST_FINAL;
							end
						end
					end
					ST_FINAL:
					begin
						next_st.state = ST_IDLE;
						if (i_cmd_size != SIZE_BYTE)
						begin
							err_set[B_ILGCOM] = 1'b1;
							err_set[B_ILGL] = 1'b1;
						end
						else if (i_cmd_data != CMD_FINAL)
						begin
							err_set[B_ILGCOM] = 1'b1;
							err_set[B_ILGL] = 1'b1;
						end
						else if (addr_bad)
						begin
							err_set[B_ILGCOM] = 1'b1;
							err_set[B_ILGL] = 1'b1;
						end
						else if (i_valid_area_hit && (st.op == OP_PROG || st.op == OP_BERASE))
						begin
							err_set[B_CFA] = 1'b1;
							err_set[B_ILGL] = 1'b1;
						end
						else if (i_protect_violation)
						begin
							err_set[B_SEC] = 1'b1;
							err_set[B_ILGL] = 1'b1;
						end
						else
						begin
							next_st.start = 1'b1;
							next_st.susp_mode = i_mode_entry_reg;
							next_st.state = ST_BUSY;
						end
					end
					ST_BUSY:
					begin
						// clear while not ready is ignored
						if (i_cmd_data == CMD_SUSPEND && !i_op_done)
						begin
							next_st.suspend = 1'b1;
							next_st.state = ST_SUSP;
						end
						else if (i_cmd_data != CMD_CLEAR)
						begin
							err_set[B_ILGCOM] = 1'b1;
							err_set[B_ILGL] = 1'b1;
						end
					end
					default:
					begin
						next_st.state = ST_IDLE;
					end
				endcase
			end
		end

		// a set of the illegal bit aborts a half-written command but never a running operation
		if (err_set[B_ILGL])
		begin
			err_set[B_LOCK] = 1'b1;
			if (st.state != ST_BUSY && st.state != ST_SUSP && !next_st.abort)
			begin
				next_st.state = ST_IDLE;
			end
		end

		// a locked sequencer never starts the array
		if (locked || err_set[B_LOCK])
		begin
			next_st.start = 1'b0;
			next_st.resume = 1'b0;
		end

		err_set[B_ECC +: NECC] = i_ecc_detect;
		next_st.ready = (next_st.state != ST_BUSY);
		next_st.irq = i_lock_irq_enable && (err_set[B_LOCK] || (locked && !err_clr));
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			st <= '{state: ST_IDLE, op: OP_PROG, cnt: '0, susp_mode: MODE_READ,
				hv_prev: 1'b0, ready: 1'b1, start: 1'b0, suspend: 1'b0,
				resume: 1'b0, abort: 1'b0, irq: 1'b0};
		end
		else
		begin
			st <= next_st;
		end
	end

	// status bits hold until a clear or stop command
	fclg_sticky #(
		.W(NERR)
	) u_status (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_set(err_set),
		.i_clr(err_clr),
		.o_q(errs)
	);

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign o_sequencer_ready_flag = st.ready;
	assign o_op_start = st.start;
	assign o_op_kind = st.op;
	assign o_op_suspend = st.suspend;
	assign o_op_resume = st.resume;
	assign o_op_abort = st.abort;
	assign o_flash_access_error_irq = st.irq;
	assign o_lock_status_bit = errs[B_LOCK];
	assign o_illegal_error_bit = errs[B_ILGL];
	assign o_illegal_command_bit = errs[B_ILGCOM];
	assign o_mode_setting_error_bit = errs[B_MODE];
	assign o_erase_error_bit = errs[B_ERS];
	assign o_program_error_bit = errs[B_PRG];
	assign o_code_area_access_error = errs[B_CFA];
	assign o_data_area_access_error = errs[B_DFA];
	assign o_security_error_bit = errs[B_SEC];
	assign o_operation_timing_error = errs[B_OT];
	assign o_high_voltage_enable_error = errs[B_HVE];
	assign o_security_area_ecc_detect = errs[B_ECC + E_SEC];
	assign o_protect_area_ecc_detect = errs[B_ECC + E_BPL];
	assign o_config_area_ecc_detect = errs[B_ECC + E_CFG];
	assign o_param_table_ecc_detect = errs[B_ECC + E_TBL];
	assign o_switch_area_ecc_detect = errs[B_ECC + E_SWT];
	assign o_erase_count_ecc_detect = errs[B_ECC + E_ERC];
endmodule

// ==== inc/fclg_pkg.sv ====
// constants and types shared by the flash command lock guard
package fclg_pkg;
	// widths
	localparam int DATA_W = 32;
	localparam int ADDR_W = 21;
	localparam int MODE_W = 16;
	localparam int NERR = 17;
	localparam int NECC = 6;
	localparam int CNT_W = 5;

	// mode entry values
	localparam logic [MODE_W-1:0] MODE_READ = 16'h0000;
	localparam logic [MODE_W-1:0] MODE_CODE_PE = 16'h0001;
	localparam logic [MODE_W-1:0] MODE_DATA_PE = 16'h0080;

	// command codes written to the command port, and the program word counter constants
	localparam logic [DATA_W-1:0] CMD_CLEAR = 32'h0000_0050;
	localparam logic [DATA_W-1:0] CMD_FSTOP = 32'h0000_00b3;
	localparam logic [DATA_W-1:0] CMD_PROG = 32'h0000_00e8;
	localparam logic [DATA_W-1:0] CMD_BLK_ERASE = 32'h0000_0020;
	localparam logic [DATA_W-1:0] CMD_AREA_ERASE = 32'h0000_0084;
	localparam logic [DATA_W-1:0] CMD_BLANK = 32'h0000_0071;
	localparam logic [DATA_W-1:0] CMD_SUSPEND = 32'h0000_00b0;
	localparam logic [DATA_W-1:0] CMD_FINAL = 32'h0000_00d0;
	localparam logic [DATA_W-1:0] PROG_WORDS = 32'h0000_0004;
	localparam logic [CNT_W-1:0] PROG_CNT = 5'h04;
	localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;

	// access sizes
	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_HALF = 2'h1;
	localparam logic [1:0] SIZE_WORD = 2'h2;

	// positions in the sticky error vector
	localparam int B_ILGL = 0;
	localparam int B_ILGCOM = 1;
	localparam int B_MODE = 2;
	localparam int B_ERS = 3;
	localparam int B_PRG = 4;
	localparam int B_CFA = 5;
	localparam int B_DFA = 6;
	localparam int B_SEC = 7;
	localparam int B_OT = 8;
	localparam int B_HVE = 9;
	localparam int B_ECC = 10;
	localparam int B_LOCK = 16;

	// ecc detect inputs, index order
	localparam int E_SEC = 0;
	localparam int E_BPL = 1;
	localparam int E_CFG = 2;
	localparam int E_TBL = 3;
	localparam int E_SWT = 4;
	localparam int E_ERC = 5;

	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b000,
		ST_COUNT = 3'b001,
		ST_DATA = 3'b010,
		ST_FINAL = 3'b011,
		ST_BUSY = 3'b100,
		ST_SUSP = 3'b101
	} fclg_state_t;

	typedef enum logic [1:0]
	{
		OP_PROG = 2'b00,
		OP_BERASE = 2'b01,
		OP_AERASE = 2'b10,
		OP_BLANK = 2'b11
	} fclg_op_t;
endpackage

// ==== logic/fclg_sticky.sv ====
`timescale 1ns/10ps
// bank of sticky status bits, set has priority over clear
module fclg_sticky #(
	parameter int W = 1
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic [W-1:0] i_set,
	input wire logic i_clr,
	output logic [W-1:0] o_q
);
	typedef struct packed
	{
		logic [W-1:0] q;
	} fclg_stk_t;

	fclg_stk_t st;
	fclg_stk_t next_st;

	// an event landing on the clear cycle must survive, so set is or-ed last
	always_comb
	begin
		next_st = st;
		if (i_clr)
		begin
			next_st.q = '0;
		end
		next_st.q = next_st.q | i_set;
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			st <= '0;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign o_q = st.q;
endmodule

// ==== sim/fclg_guard_props.sv ====
`timescale 1ns/10ps
// port assertions for the flash command lock guard
module fclg_guard_props
	import fclg_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_cmd_wr,
	input wire logic i_cmd_rd,
	input wire logic [fclg_pkg::DATA_W-1:0] i_cmd_data,
	input wire logic [1:0] i_cmd_size,
	input wire logic [fclg_pkg::MODE_W-1:0] i_mode_entry_reg,
	input wire logic i_lock_irq_enable,
	input wire logic i_valid_area_hit,
	input wire logic i_protect_violation,
	input wire logic i_op_done,
	input wire logic i_op_fail,
	input wire logic o_sequencer_ready_flag,
	input wire logic o_op_start,
	input wire logic [1:0] o_op_kind,
	input wire logic o_op_suspend,
	input wire logic o_flash_access_error_irq,
	input wire logic o_lock_status_bit,
	input wire logic o_illegal_error_bit,
	input wire logic o_mode_setting_error_bit,
	input wire logic o_erase_error_bit,
	input wire logic o_operation_timing_error
);
	// ----
	// shorthand for command decodes
	// ----
	wire logic ok_mode = i_mode_entry_reg inside {MODE_READ, MODE_CODE_PE, MODE_DATA_PE};
	wire logic stop = i_cmd_wr && i_cmd_data == CMD_FSTOP;
	wire logic clr = i_cmd_wr && i_cmd_data == CMD_CLEAR;
	wire logic sus = i_cmd_wr && i_cmd_data == CMD_SUSPEND;
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rst_n);
	// two-cycle erase request; excludes lock, busy, mode and area refusals, but not a bad final size, a read or a dma cross
	sequence s_erase_go;
		i_cmd_wr && i_cmd_data == CMD_BLK_ERASE && i_cmd_size == SIZE_BYTE && i_mode_entry_reg == MODE_CODE_PE
		&& !o_lock_status_bit && o_sequencer_ready_flag
		##1 i_cmd_wr && i_cmd_data == CMD_FINAL && !i_valid_area_hit && !i_protect_violation;
	endsequence
	chk_erase_start: assert property (s_erase_go |=> o_op_start && o_op_kind == OP_BERASE)
		else $error("erase request did not start");
	chk_no_start: assert property ($past(o_lock_status_bit) |-> !o_op_start)
		else $error("operation started while locked");
	chk_clear_unlock: assert property (clr && o_sequencer_ready_flag && ok_mode && !o_mode_setting_error_bit
		|=> !o_lock_status_bit) else $error("status clear left lock set");
	chk_stop_unlock: assert property (stop && ok_mode |=> !o_lock_status_bit && !o_illegal_error_bit)
		else $error("forced stop left lock set");
	chk_irq_follow: assert property (o_flash_access_error_irq == (o_lock_status_bit && $past(i_lock_irq_enable)))
		else $error("access irq not following lock");
	chk_run_holds: assert property (!o_sequencer_ready_flag && !i_op_done && !stop
		&& !(sus && !o_lock_status_bit) |=> !o_sequencer_ready_flag) else $error("operation cut short");
	chk_susp_locked: assert property (sus && o_lock_status_bit |=> !o_op_suspend)
		else $error("suspend accepted while locked");
	chk_locked_write: assert property (i_cmd_wr && o_lock_status_bit && !stop && !clr && !i_op_done
		|=> o_illegal_error_bit && o_lock_status_bit && $stable(o_erase_error_bit) && $stable(o_mode_setting_error_bit))
		else $error("locked write changed other bits");
	chk_mode_bad: assert property (i_cmd_wr && !ok_mode && !o_lock_status_bit && !stop
		|=> o_mode_setting_error_bit && o_illegal_error_bit) else $error("bad mode entry not flagged");
	chk_fail_nolock: assert property (i_op_done && i_op_fail && !i_cmd_wr && !o_illegal_error_bit
		|=> !o_lock_status_bit && !o_illegal_error_bit) else $error("array failure locked sequencer");
	chk_read_area: assert property (i_cmd_rd |=> o_operation_timing_error && o_illegal_error_bit && o_lock_status_bit)
		else $error("command area read not flagged");
endmodule
bind fclg_guard fclg_guard_props u_fclg_guard_props (
	.i_clk_sys, .i_rst_n, .i_cmd_wr, .i_cmd_rd, .i_cmd_data, .i_cmd_size, .i_mode_entry_reg,
	.i_lock_irq_enable, .i_valid_area_hit, .i_protect_violation, .i_op_done, .i_op_fail,
	.o_sequencer_ready_flag, .o_op_start, .o_op_kind, .o_op_suspend, .o_flash_access_error_irq,
	.o_lock_status_bit, .o_illegal_error_bit, .o_mode_setting_error_bit, .o_erase_error_bit,
	.o_operation_timing_error
);

// ==== sim/fclg_host.sv ====
`timescale 1ns/10ps
// cpu side model that writes the command port
module fclg_host
	import fclg_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_ready,
	output logic o_cmd_wr,
	output logic o_cmd_rd,
	output logic [fclg_pkg::DATA_W-1:0] o_cmd_data,
	output logic [1:0] o_cmd_size
);
	// quiet at time zero
	initial
	begin
		o_cmd_wr = 1'b0;
		o_cmd_rd = 1'b0;
		o_cmd_data = 32'h0;
		o_cmd_size = 2'h0;
	end
	// called at a falling edge; strobe stays up so writes run back to back
	task automatic wr(input logic [31:0] d, input logic [1:0] z);
		o_cmd_wr = 1'b1;
		o_cmd_data = d;
		o_cmd_size = z;
		@(negedge i_clk_sys);
	endtask
	// released data is inverted so a stale code looks invalid, until a second idle in a row restores it
	task automatic idle();
		o_cmd_wr = 1'b0;
		o_cmd_rd = 1'b0;
		o_cmd_data = ~o_cmd_data;
		@(negedge i_clk_sys);
	endtask
	// write only area: read made only when a test orders it
	task automatic rd();
		o_cmd_rd = 1'b1;
		@(negedge i_clk_sys);
	endtask
	// status clear is withheld while the sequencer is busy
	task automatic clr();
		if (i_ready) wr(CMD_CLEAR, SIZE_BYTE);
	endtask
endmodule

// ==== sim/testbench.sv ====
`timescale 1ns/10ps
// self-checking bench for the flash command lock guard
module testbench;
	import fclg_pkg::*;
	logic i_clk_sys = 1'b0;
	logic i_rst_n = 1'b0;
	logic [MODE_W-1:0] mode = MODE_CODE_PE;
	logic [ADDR_W-1:0] sa = 21'h0;
	logic [ADDR_W-1:0] ea = 21'h0;
	logic dir = 1'b0, ie = 1'b1, hv = 1'b1, vah = 1'b0, pv = 1'b0, dma = 1'b0, done = 1'b0, fail = 1'b0;
	logic [NECC-1:0] ecc = 6'h0;
	logic wr, rd, rdy, start, susp, resm, abrt, irq;
	logic [DATA_W-1:0] data;
	logic [1:0] size, kind;
	wire logic [16:0] s;
	int err_total = 0;
	int comparisons = 0;
	always #20 i_clk_sys = ~i_clk_sys;
	fclg_host u_fclg_host (.i_clk_sys(i_clk_sys), .i_ready(rdy), .o_cmd_wr(wr), .o_cmd_rd(rd),
		.o_cmd_data(data), .o_cmd_size(size));
	// status outputs packed in the package's bit order
	fclg_guard u_fclg_guard (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_cmd_wr(wr), .i_cmd_rd(rd),
		.i_cmd_data(data), .i_cmd_size(size), .i_mode_entry_reg(mode), .i_start_address(sa),
		.i_end_address(ea), .i_blank_check_direction(dir), .i_lock_irq_enable(ie),
		.i_high_voltage_enable_ctrl(hv), .i_valid_area_hit(vah), .i_protect_violation(pv),
		.i_dma_area_cross(dma), .i_op_done(done), .i_op_fail(fail), .i_ecc_detect(ecc),
		.o_sequencer_ready_flag(rdy), .o_op_start(start), .o_op_kind(kind), .o_op_suspend(susp),
		.o_op_resume(resm), .o_op_abort(abrt), .o_flash_access_error_irq(irq), .o_lock_status_bit(s[16]),
		.o_illegal_error_bit(s[0]), .o_illegal_command_bit(s[1]), .o_mode_setting_error_bit(s[2]),
		.o_erase_error_bit(s[3]), .o_program_error_bit(s[4]), .o_code_area_access_error(s[5]),
		.o_data_area_access_error(s[6]), .o_security_error_bit(s[7]), .o_operation_timing_error(s[8]),
		.o_high_voltage_enable_error(s[9]), .o_security_area_ecc_detect(s[10]),
		.o_protect_area_ecc_detect(s[11]), .o_config_area_ecc_detect(s[12]),
		.o_param_table_ecc_detect(s[13]), .o_switch_area_ecc_detect(s[14]), .o_erase_count_ecc_detect(s[15]));
	task automatic chk(input string n, input logic [16:0] e, input logic [16:0] g);
		comparisons++;
		if (g !== e)
		begin
			$display("wrong value %s expected %h seen %h", n, e, g);
			err_total++;
		end
	endtask
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic w(input logic [31:0] d);
		u_fclg_host.wr(d, SIZE_BYTE);
	endtask
	task automatic w2(input logic [31:0] d);
		w(d);
		w(CMD_FINAL);
	endtask
	task automatic pulse(ref logic p);
		p = 1'b1;
		@(negedge i_clk_sys);
		p = 1'b0;
	endtask
	// bounded wait for ready, then clear and confirm all bits drop
	task automatic clean(input string n);
		for (int k = 0; k < 50 && rdy !== 1'b1; k++)
			@(negedge i_clk_sys);
		if (rdy !== 1'b1)
		begin
			err_total++;
			end_sim();
		end
		u_fclg_host.clr();
		u_fclg_host.idle();
		chk("cleared", 17'h0, s);
		$display("test %s done", n);
	endtask
	task automatic fin(input string n, input logic [16:0] e);
		u_fclg_host.idle();
		chk(n, e, s);
		chk("irq", e[16] & ie, irq);
		clean(n);
	endtask
	initial
	begin
		repeat (3) @(negedge i_clk_sys);
		i_rst_n = 1'b1;
		chk("reset", 17'h0, s);
		chk("ready", 17'h1, rdy);
		w(32'h11);
		w2(CMD_BLK_ERASE);
		chk("locked start", 17'h0, start);
		fin("bad code", 17'h10003);
		mode = MODE_READ;
		ie = 1'b0;
		w(CMD_BLK_ERASE);
		fin("read mode", 17'h10101);
		mode = 16'h0002;
		ie = 1'b1;
		w(CMD_BLK_ERASE);
		mode = MODE_CODE_PE;
		fin("mode", 17'h10005);
		w(CMD_PROG);
		w(32'h3);
		fin("count", 17'h10003);
		w(CMD_BLK_ERASE);
		w(32'h55);
		fin("final", 17'h10003);
		u_fclg_host.wr(CMD_BLK_ERASE, SIZE_WORD);
		fin("size", 17'h10003);
		// area erase, ascending and descending blank check, each inverted
		for (int i = 0; i < 3; i++)
		begin
			dir = (i == 2);
			sa = (i == 2) ? 21'h0ff : 21'h100;
			ea = (i == 2) ? 21'h100 : 21'h0ff;
			w2((i == 0) ? CMD_AREA_ERASE : CMD_BLANK);
			fin("address", 17'h10003);
		end
		vah = 1'b1;
		w2(CMD_BLK_ERASE);
		vah = 1'b0;
		fin("valid area", 17'h10021);
		pv = 1'b1;
		w2(CMD_BLK_ERASE);
		pv = 1'b0;
		fin("protect", 17'h10081);
		pulse(dma);
		fin("dma cross", 17'h10041);
		u_fclg_host.rd();
		fin("read", 17'h10101);
		for (int i = 0; i < 6; i++)
		begin
			ecc = 6'h1 << i;
			@(negedge i_clk_sys);
			ecc = 6'h0;
			chk("ecc", 17'h1 << i, s[15:10]);
			clean("ecc");
		end
		// lock during erase: run goes on, suspend ignored, stop cancels
		w2(CMD_BLK_ERASE);
		chk("erase start", {OP_BERASE, 1'b1}, {kind, start});
		w(32'h11);
		w(CMD_SUSPEND);
		chk("suspend", 17'h0, susp);
		u_fclg_host.idle();
		chk("busy ready", 17'h0, rdy);
		chk("busy lock", 17'h10003, s);
		w(CMD_FSTOP);
		chk("abort", 17'h1, abrt);
		u_fclg_host.idle();
		chk("stop", 17'h0, s);
		w(CMD_PROG);
		w(PROG_WORDS);
		for (int i = 0; i < 4; i++)
			u_fclg_host.wr(32'h1234_5670 + i, SIZE_WORD);
		w(CMD_FINAL);
		chk("prog start", {OP_PROG, 1'b1}, {kind, start});
		hv = 1'b0;
		u_fclg_host.idle();
		fail = 1'b1;
		pulse(done);
		fail = 1'b0;
		hv = 1'b1;
		chk("prog ready", 17'h1, rdy);
		fin("prog fail", 17'h00210);
		w2(CMD_BLK_ERASE);
		u_fclg_host.idle();
		fail = 1'b1;
		pulse(done);
		fail = 1'b0;
		fin("erase fail", 17'h00008);
		w2(CMD_BLK_ERASE);
		w(CMD_SUSPEND);
		chk("suspend go", 17'h1, susp);
		mode = MODE_DATA_PE;
		w(CMD_FINAL);
		mode = MODE_CODE_PE;
		chk("resume", 17'h0, resm);
		fin("resume", 17'h10001);
		w(CMD_FSTOP);
		u_fclg_host.idle();
		end_sim();
	end
endmodule
